// ==== common/sas_pkg.sv ====
package sas_pkg;
    localparam int RES_W = 10;
    localparam int CHAN_W = 3;
    localparam int CONV_PERIODS = 11;
    localparam int ABORT_PERIODS = 2;
    localparam int CNT_W = 4;
    localparam int DIV_W = 6;
    localparam logic [2:0] CCS_DIV2 = 3'h0;
    localparam logic [2:0] CCS_DIV4 = 3'h4;
    localparam logic [2:0] CCS_DIV8 = 3'h1;
    localparam logic [2:0] CCS_DIV16 = 3'h5;
    localparam logic [2:0] CCS_DIV32 = 3'h2;
    localparam logic [2:0] CCS_DIV64 = 3'h6;
    localparam logic [1:0] CCS_RC_LOW = 2'h3;
    localparam logic [5:0] DIV2_TERM = 6'h00;
    localparam logic [5:0] DIV4_TERM = 6'h01;
    localparam logic [5:0] DIV8_TERM = 6'h03;
    localparam logic [5:0] DIV16_TERM = 6'h07;
    localparam logic [5:0] DIV32_TERM = 6'h0f;
    localparam logic [5:0] DIV64_TERM = 6'h1f;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_HOLD = 2'b10
    } sas_state_e;

    typedef struct packed {
        logic converter_on;
        logic go;
        logic go_clear;
        logic [CHAN_W-1:0] channel_select;
        logic ref_select;
        logic result_justify;
        logic [2:0] conv_clock_select;
    } sas_ctrl_s;

    typedef struct packed {
        logic [7:0] result_high;
        logic [7:0] result_low;
    } sas_result_s;
endpackage

// ==== hdl/sas_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
// One system-clock pulse per conversion-clock period
module sas_tick_gen
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] sel,
    input wire logic rc_tick,
    output logic tick
);
    logic [sas_pkg::DIV_W-1:0] cnt_q;
    logic [sas_pkg::DIV_W-1:0] term;

    always_comb
    begin
        unique case (sel)
            sas_pkg::CCS_DIV2: term = sas_pkg::DIV2_TERM;
            sas_pkg::CCS_DIV4: term = sas_pkg::DIV4_TERM;
            sas_pkg::CCS_DIV8: term = sas_pkg::DIV8_TERM;
            sas_pkg::CCS_DIV16: term = sas_pkg::DIV16_TERM;
            sas_pkg::CCS_DIV32: term = sas_pkg::DIV32_TERM;
            sas_pkg::CCS_DIV64: term = sas_pkg::DIV64_TERM;
            default: term = sas_pkg::DIV2_TERM;
        endcase
    end

    // Divided sources track the system clock; RC ticks do not
    always_ff @(posedge clk)
    begin
        if (!rst_n || !run)
            cnt_q <= '0;
        else if (cnt_q >= term)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    assign tick = (sel[1:0] == sas_pkg::CCS_RC_LOW) ? rc_tick
                                                    : (run && cnt_q >= term);
endmodule // sas_tick_gen
`default_nettype wire

// ==== hdl/sas_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    // Software control
    input wire sas_pkg::sas_ctrl_s CTRL_IN,
    input wire logic FLAG_CLEAR_IN,
    input wire logic IRQ_ENABLE_IN,
    input wire logic GLOBAL_IRQ_ENABLE_IN,
    input wire logic SLEEPING_IN,
    // Analog front end
    input wire logic RC_TICK_IN,
    input wire logic COMPARATOR_IN,
    output logic [sas_pkg::CHAN_W-1:0] CHANNEL_SELECT_OUT,
    output logic REF_SELECT_OUT,
    output logic SAMPLE_HOLD_OUT,
    output logic [sas_pkg::RES_W-1:0] DAC_CODE_OUT,
    // Status and results
    output logic GO_BUSY_OUT,
    output logic CONV_DONE_FLAG_OUT,
    output logic PERIPH_IRQ_OUT,
    output logic WAKE_OUT,
    output logic BRANCH_ISR_OUT,
    output sas_pkg::sas_result_s RESULT_OUT
);
    sas_pkg::sas_state_e state_q;
    logic [sas_pkg::CNT_W-1:0] period_q;
    logic [sas_pkg::RES_W-1:0] sar_q;
    logic [sas_pkg::RES_W-1:0] trial_q;
    logic [2:0] rc_sync_q;
    logic rc_tick;
    logic tick;
    logic finish;
    logic wake_d;

    // Internal RC arrives from another domain: count a rising change
    // only once the second and third stage agree
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            rc_sync_q <= '0;
        else
            rc_sync_q <= {rc_sync_q[1:0], RC_TICK_IN};
    end

    logic rc_seen_q;
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            rc_seen_q <= 1'b0;
        else if (rc_sync_q[2] == rc_sync_q[1])
            rc_seen_q <= rc_sync_q[2];
    end
    assign rc_tick = (rc_sync_q[2] == rc_sync_q[1]) && rc_sync_q[2]
                     && !rc_seen_q;

    sas_tick_gen u_tick
    (
        .clk(CLK_SYS_IN),
        .rst_n(RESET_N_IN),
        .run(state_q != sas_pkg::ST_IDLE),
        .sel(CTRL_IN.conv_clock_select),
        .rc_tick(rc_tick),
        .tick(tick)
    );

    assign finish = (state_q == sas_pkg::ST_CONV) && tick
        && (period_q == sas_pkg::CNT_W'(sas_pkg::CONV_PERIODS - 1));

    // Sequencer: idle, converting, and post-abort hold
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            state_q <= sas_pkg::ST_IDLE;
        else
        begin
            unique case (state_q)
                sas_pkg::ST_IDLE:
                    if (CTRL_IN.converter_on && CTRL_IN.go)
                        state_q <= sas_pkg::ST_CONV;
                sas_pkg::ST_CONV:
                    if (!CTRL_IN.converter_on)
                        state_q <= sas_pkg::ST_IDLE;
                    else if (CTRL_IN.go_clear)
                        state_q <= sas_pkg::ST_HOLD;
                    else if (finish)
                        state_q <= sas_pkg::ST_IDLE;
                sas_pkg::ST_HOLD:
                    if (tick && period_q ==
                        sas_pkg::CNT_W'(sas_pkg::ABORT_PERIODS - 1))
                        state_q <= sas_pkg::ST_IDLE;
                default:
                    state_q <= sas_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            period_q <= '0;
        else if (state_q == sas_pkg::ST_IDLE || finish
                 || (state_q == sas_pkg::ST_CONV && CTRL_IN.go_clear))
            period_q <= '0;
        else if (tick)
            period_q <= period_q + 1'b1;
    end

    logic [sas_pkg::RES_W-1:0] sar_d;
    logic [sas_pkg::RES_W-1:0] trial_d;

    // Successive approximation, MSB first after the first period
    always_comb
    begin
        sar_d = sar_q;
        trial_d = trial_q;
        if (state_q != sas_pkg::ST_CONV)
        begin
            sar_d = '0;
            trial_d = '0;
        end
        else if (tick && period_q == '0)
            trial_d = {1'b1, {(sas_pkg::RES_W-1){1'b0}}};
        else if (tick)
        begin
            if (COMPARATOR_IN)
                sar_d = sar_q | trial_q;
            trial_d = trial_q >> 1;
        end
    end

    // Trial code registered from next values, so the comparator sees
    // the current trial even when ticks come every cycle
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
        begin
            sar_q <= '0;
            trial_q <= '0;
            DAC_CODE_OUT <= '0;
        end
        else
        begin
            sar_q <= sar_d;
            trial_q <= trial_d;
            DAC_CODE_OUT <= sar_d | trial_d;
        end
    end

    // Result pair updates only on a completed conversion
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            RESULT_OUT <= '0;
        else if (finish)
        begin
            if (CTRL_IN.result_justify)
                RESULT_OUT <= {6'h00, (COMPARATOR_IN ? sar_q | trial_q
                                                      : sar_q)};
            else
                RESULT_OUT <= {(COMPARATOR_IN ? sar_q | trial_q : sar_q),
                               6'h00};
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            GO_BUSY_OUT <= 1'b0;
        else
            GO_BUSY_OUT <= (state_q == sas_pkg::ST_CONV) && !finish
                           && !CTRL_IN.go_clear && CTRL_IN.converter_on
                           || (state_q == sas_pkg::ST_IDLE && CTRL_IN.go
                               && CTRL_IN.converter_on);
    end

    // Set wins over a coincident software clear
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
            CONV_DONE_FLAG_OUT <= 1'b0;
        else if (finish)
            CONV_DONE_FLAG_OUT <= 1'b1;
        else if (FLAG_CLEAR_IN)
            CONV_DONE_FLAG_OUT <= 1'b0;
    end

    assign wake_d = (CONV_DONE_FLAG_OUT || finish) && IRQ_ENABLE_IN;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
        begin
            PERIPH_IRQ_OUT <= 1'b0;
            WAKE_OUT <= 1'b0;
            BRANCH_ISR_OUT <= 1'b0;
        end
        else
        begin
            PERIPH_IRQ_OUT <= wake_d;
            WAKE_OUT <= wake_d && SLEEPING_IN;
            // Branch is flagged in the same cycle as the request and wake, only with the global enable
            BRANCH_ISR_OUT <= wake_d && GLOBAL_IRQ_ENABLE_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RESET_N_IN)
        begin
            CHANNEL_SELECT_OUT <= '0;
            REF_SELECT_OUT <= 1'b0;
            SAMPLE_HOLD_OUT <= 1'b0;
        end
        else
        begin
            CHANNEL_SELECT_OUT <= CTRL_IN.channel_select;
            REF_SELECT_OUT <= CTRL_IN.ref_select;
            // Track while on and not converting; hold during conversion
            SAMPLE_HOLD_OUT <= CTRL_IN.converter_on
                               && state_q != sas_pkg::ST_CONV
                               && !(state_q == sas_pkg::ST_IDLE
                                    && CTRL_IN.go);
        end
    end
endmodule // sas_sequencer
`default_nettype wire

// ==== bench/sas_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_checker
(
    // Inputs to the block
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire sas_pkg::sas_ctrl_s CTRL_IN,
    input wire logic FLAG_CLEAR_IN,
    input wire logic IRQ_ENABLE_IN,
    input wire logic GLOBAL_IRQ_ENABLE_IN,
    input wire logic SLEEPING_IN,
    // Outputs of the block
    input wire logic GO_BUSY_OUT,
    input wire logic SAMPLE_HOLD_OUT,
    input wire logic CONV_DONE_FLAG_OUT,
    input wire logic PERIPH_IRQ_OUT,
    input wire logic WAKE_OUT,
    input wire logic BRANCH_ISR_OUT,
    input wire sas_pkg::sas_result_s RESULT_OUT
);
default clocking @(posedge CLK_SYS_IN); endclocking
default disable iff (!RESET_N_IN);
sequence busy_ten;
    GO_BUSY_OUT [*8] ##1 GO_BUSY_OUT [*2];
endsequence
flag_sticky_a: assert property (
    CONV_DONE_FLAG_OUT && !FLAG_CLEAR_IN |=> CONV_DONE_FLAG_OUT)
    else $error("done flag dropped without clear");
conv_length_a: assert property (
    $rose(GO_BUSY_OUT) && CTRL_IN.conv_clock_select == sas_pkg::CCS_DIV2
    |-> busy_ten ##[1:3] !GO_BUSY_OUT)
    else $error("fast conversion length wrong");
done_ends_go_a: assert property (
    $rose(CONV_DONE_FLAG_OUT) |-> ##[0:1] !GO_BUSY_OUT)
    else $error("busy stayed after done");
start_cause_a: assert property (
    $rose(GO_BUSY_OUT) |-> $past(CTRL_IN.converter_on && CTRL_IN.go))
    else $error("conversion started without request");
hold_convert_a: assert property (
    GO_BUSY_OUT |-> !SAMPLE_HOLD_OUT)
    else $error("tracking during conversion");
result_kept_a: assert property (
    !$stable(RESULT_OUT) |-> CONV_DONE_FLAG_OUT)
    else $error("result changed without completion");
irq_mask_a: assert property (
    !IRQ_ENABLE_IN && !$past(IRQ_ENABLE_IN) |-> !PERIPH_IRQ_OUT)
    else $error("request while disabled");
wake_sleep_a: assert property (
    !SLEEPING_IN && !$past(SLEEPING_IN) |-> !WAKE_OUT)
    else $error("wake while awake");
branch_global_a: assert property (
    !GLOBAL_IRQ_ENABLE_IN && !$past(GLOBAL_IRQ_ENABLE_IN)
    |-> !BRANCH_ISR_OUT)
    else $error("branch while globally disabled");
endmodule // sas_checker
bind sas_sequencer sas_checker chk (.*);
`default_nettype wire

// ==== bench/sas_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model
(
    input wire logic [2:0] chan_in,
    input wire logic track_in,
    input wire logic [9:0] code_in,
    output logic cmp_out,
    output logic rc_out
);
logic [9:0] held;
// Free-running oscillator, deliberately not a multiple of the clock
initial
begin
    rc_out = 1'b0;
    forever #21 rc_out = ~rc_out;
end
// One shared hold capacitor, frozen while converting
always @*
    if (track_in)
        held = {chan_in, 7'h2b};
assign cmp_out = held >= code_in;
endmodule // sas_analog_model
`default_nettype wire

// ==== bench/sas_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_tb;
logic clk, rst_n, fclr, ien, gien, slp, rc, cmp, sh, busy, flag;
logic irq, wake, br, ref_o;
logic [2:0] chan_o;
logic [9:0] dac;
sas_pkg::sas_ctrl_s ctrl;
sas_pkg::sas_result_s res;
int err_total, checks_done;
sas_sequencer DUT (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CTRL_IN(ctrl),
    .FLAG_CLEAR_IN(fclr), .IRQ_ENABLE_IN(ien), .GLOBAL_IRQ_ENABLE_IN(gien),
    .SLEEPING_IN(slp), .RC_TICK_IN(rc), .COMPARATOR_IN(cmp),
    .CHANNEL_SELECT_OUT(chan_o), .REF_SELECT_OUT(ref_o),
    .SAMPLE_HOLD_OUT(sh), .DAC_CODE_OUT(dac), .GO_BUSY_OUT(busy),
    .CONV_DONE_FLAG_OUT(flag), .PERIPH_IRQ_OUT(irq), .WAKE_OUT(wake),
    .BRANCH_ISR_OUT(br), .RESULT_OUT(res));
sas_analog_model afe (.chan_in(chan_o), .track_in(sh), .code_in(dac),
    .cmp_out(cmp), .rc_out(rc));
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [15:0] e,
                   input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
        err_total++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic wait_for(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl)
    begin
        @(negedge clk);
        n++;
        if (n > 2000)
        begin
            err_total++;
            close_out();
        end
    end
endtask
task automatic clr_flag();
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    @(negedge clk);
    chk("clear", 16'h0, {15'h0, flag});
endtask
task automatic conv(input logic [2:0] cs, input logic [2:0] ch,
                    input logic rj, output int n);
    logic [9:0] v;
    v = {ch, 7'h2b};
    ctrl.channel_select = ch;
    ctrl.ref_select = ch[1];
    ctrl.conv_clock_select = cs;
    ctrl.result_justify = rj;
    ctrl.converter_on = 1'b1;
    // Settling time after a channel change
    repeat (4) @(negedge clk);
    chk("route", {12'h0, ch[1], ch}, {12'h0, ref_o, chan_o});
    ctrl.go = 1'b1;
    wait_for(1'b1, n);
    ctrl.go = 1'b0;
    wait_for(1'b0, n);
    chk("flag", 16'h1, {15'h0, flag});
    chk("result", rj ? 16'(v) : {v, 6'h00}, res);
endtask
task automatic t_clocks();
    logic [2:0] cs [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int lo [8] = '{11, 22, 44, 88, 176, 352, 42, 42};
    int n;
    for (int i = 0; i < 8; i++)
    begin
        slp = (cs[i][1:0] == 2'h3);
        conv(cs[i], 3'(i), i[0], n);
        slp = 1'b0;
        chk("length", 16'h1, 16'(n >= lo[i] - 1 && n <= lo[i] * 9 / 8 + 3));
        clr_flag();
    end
    $display("test clocks done");
endtask
task automatic t_irq();
    int n;
    conv(3'h0, 3'h5, 1'b0, n);
    repeat (20) @(negedge clk);
    chk("sticky", 16'h1, {15'h0, flag});
    chk("masked", 16'h0, {15'h0, irq});
    ien = 1'b1;
    slp = 1'b1;
    repeat (2) @(negedge clk);
    chk("wake", 16'h6, {13'h0, irq, wake, br});
    gien = 1'b1;
    repeat (2) @(negedge clk);
    chk("branch", 16'h7, {13'h0, irq, wake, br});
    {ien, gien, slp} = 3'h0;
    clr_flag();
    $display("test irq done");
endtask
task automatic t_abort();
    sas_pkg::sas_result_s old;
    int n;
    old = res;
    ctrl.conv_clock_select = sas_pkg::CCS_DIV4;
    ctrl.go = 1'b1;
    wait_for(1'b1, n);
    ctrl.go = 1'b0;
    repeat (6) @(negedge clk);
    ctrl.go_clear = 1'b1;
    @(negedge clk);
    ctrl.go_clear = 1'b0;
    wait_for(1'b0, n);
    chk("abort", old, res);
    chk("aflag", 16'h0, {15'h0, flag});
    conv(3'h4, 3'h2, 1'b1, n);
    clr_flag();
    $display("test abort done");
endtask
task automatic t_reset();
    int n;
    ctrl.go = 1'b1;
    wait_for(1'b1, n);
    rst_n = 1'b0;
    ctrl = '0;
    repeat (2) @(negedge clk);
    chk("rst", 16'h0, {busy, flag, irq, wake, br, sh, dac});
    chk("rres", 16'h0, res);
    rst_n = 1'b1;
    $display("test reset done");
endtask
initial
begin
    {rst_n, fclr, ien, gien, slp} = 5'h0;
    ctrl = '0;
    err_total = 0;
    checks_done = 0;
    repeat (20) @(negedge clk);
    chk("init", 16'h0, {busy, flag, irq, wake, br, sh, dac});
    rst_n = 1'b1;
    t_clocks();
    t_irq();
    t_abort();
    t_reset();
    close_out();
end
endmodule // sas_sequencer_tb
`default_nettype wire
